// [dv/gdc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module gdc_assertions #(
    parameter int CH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CH-1:0] external_gate_input,
    input wire logic [CH-1:0] count_pulse,
    input wire logic [CH-1:0] digital_output_one,
    input wire logic irq_request
);
    // ****************************************
    // Transfer decode
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic rd_st;
    logic rd_fn;
    logic rd_ac;
    logic wr_c0;
    logic irq_clr;
    assign done = psel && penable && pready;
    assign rd_st = done && !pwrite && paddr == gdc_pkg::ADDR_STAT0;
    assign rd_fn = done && !pwrite && paddr == gdc_pkg::ADDR_FINAL0;
    assign rd_ac = done && !pwrite && paddr == gdc_pkg::ADDR_ACT0;
    assign wr_c0 = done && pwrite && paddr == gdc_pkg::ADDR_CTRL0;
    assign irq_clr = done && ((!pwrite && paddr == gdc_pkg::ADDR_IRQ)
        || (pwrite && pwdata[gdc_pkg::CFG_START]
        && (paddr == gdc_pkg::ADDR_CFG0 || paddr == gdc_pkg::ADDR_CFG1)));
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_cfg0;
        done && pwrite && paddr == gdc_pkg::ADDR_CFG0
            && pwdata[gdc_pkg::CFG_START];
    endsequence
    // ****************************************
    // Checks
    // ****************************************
    chk_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    chk_err_refused: assert property (pslverr |-> pready && prdata == 0)
        else $error("error response malformed");
    chk_irq_drop_cause: assert property ($fell(irq_request) |->
        $past(irq_clr, 1) || $past(irq_clr, 2))
        else $error("request line fell without clear");
    chk_force_high: assert property (wr_c0 && pwdata[1:0] == 2'b11
        |-> ##[1:3] digital_output_one[0])
        else $error("forced output not set");
    chk_force_low: assert property (wr_c0 && pwdata[1:0] == 2'b00
        |-> ##[1:3] !digital_output_one[0])
        else $error("output not cleared");
    chk_cfg_clears_out: assert property (s_cfg0
        |-> ##[1:3] !digital_output_one[0])
        else $error("reconfigure left output set");
    chk_out_flag: assert property (rd_st |->
        prdata[gdc_pkg::ST_OUT] == digital_output_one[0]
        || prdata[gdc_pkg::ST_OUT] == $past(digital_output_one[0])
        || prdata[gdc_pkg::ST_OUT] == $past(digital_output_one[0], 2))
        else $error("output flag disagrees with pin");
    chk_zero_flag: assert property (rd_ac && prdata[gdc_pkg::ST_ZERO]
        |-> prdata[gdc_pkg::ST_SIGN] || prdata[13:0] == 14'h0)
        else $error("zero flag with positive count");
    chk_sign_mag: assert property (rd_ac && prdata[gdc_pkg::ST_SIGN]
        |-> prdata[13:0] != 14'h0)
        else $error("negative sign on zero count");
    chk_final_ovr: assert property (rd_fn && prdata[gdc_pkg::FN_OVR]
        |-> prdata[gdc_pkg::FN_SIGN] && prdata[13:0] > 14'd9999)
        else $error("final overrange inconsistent");
    chk_final_sign: assert property (rd_fn && prdata[gdc_pkg::FN_SIGN]
        |-> prdata[13:0] != 14'h0)
        else $error("final sign on zero value");
endmodule // gdc_assertions
`default_nettype wire

// [dv/gdc_counter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module gdc_counter_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] gate;
    logic [1:0] pulse;
    logic [1:0] digital_output_one;
    logic irq_request;
    int n_errors = 0;
    int check_count = 0;
    logic [31:0] d;
    logic e;
    always #2.5 pclk = ~pclk;
    gdc_field fld (.pclk(pclk), .gate(gate), .pulse(pulse));
    gdc_counter #(.CH(2)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_gate_input(gate),
        .count_pulse(pulse), .digital_output_one(digital_output_one),
        .irq_request(irq_request));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, d, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, d, e);
        chk("read", x, d);
    endtask
    task automatic pins(input logic [2:0] x);
        repeat (3) @(posedge pclk);
        #1;
        chk("pins", {29'h0, x}, {29'h0, irq_request, digital_output_one});
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        pins(3'b000);
        apb(1'b0, 12'h040, 32'h0, d, e);
        chk("refused", 32'h1, {31'h0, e});
        chk("refused data", 32'h0, d);
        wr(gdc_pkg::ADDR_CFG1, 32'h8001_0000);
        rd(gdc_pkg::ADDR_MODE, 32'h0);
        wr(gdc_pkg::ADDR_INIT0, 32'h3);
        wr(gdc_pkg::ADDR_CFG0, 32'h8000_0f11);
        rd(gdc_pkg::ADDR_MODE, 32'h2);
        wr(gdc_pkg::ADDR_CTRL0, 32'h1);
        rd(gdc_pkg::ADDR_STAT0, 32'h0);
        rd(gdc_pkg::ADDR_ACT0, 32'h3);
        fld.set_gate(0, 1'b1);
        rd(gdc_pkg::ADDR_STAT0, 32'h20);
        fld.pulses(0, 1);
        rd(gdc_pkg::ADDR_STAT0, 32'h30);
        rd(gdc_pkg::ADDR_ACT0, 32'h2);
        rd(gdc_pkg::ADDR_STAT0, 32'h20);
        fld.pulses(0, 3);
        rd(gdc_pkg::ADDR_STAT0, 32'h0101_4020);
        rd(gdc_pkg::ADDR_ACT0, 32'h0101_0001);
        pins(3'b101);
        rd(gdc_pkg::ADDR_IRQ, 32'h1);
        pins(3'b001);
        rd(gdc_pkg::ADDR_IRQ, 32'h0);
        fld.set_gate(0, 1'b0);
        rd(gdc_pkg::ADDR_IRQ, 32'h2);
        fld.pulses(0, 1);
        rd(gdc_pkg::ADDR_FINAL0, 32'h0001_0001);
        rd(gdc_pkg::ADDR_STAT0, 32'h0301_4000);
        fld.set_gate(0, 1'b1);
        pins(3'b000);
        rd(gdc_pkg::ADDR_STAT0, 32'h20);
        fld.set_gate(0, 1'b0);
        rd(gdc_pkg::ADDR_IRQ, 32'h2);
        fld.set_gate(0, 1'b1);
        fld.set_gate(0, 1'b0);
        rd(gdc_pkg::ADDR_IRQ, 32'h400);
        rd(gdc_pkg::ADDR_FINAL0, 32'h0004_0003);
        rd(gdc_pkg::ADDR_STAT0, 32'h0200_0000);
        rd(gdc_pkg::ADDR_FINAL0, 32'h3);
        wr(gdc_pkg::ADDR_INIT0, 32'h0000_d8f2);
        wr(gdc_pkg::ADDR_CFG0, 32'h8000_0211);
        fld.set_gate(0, 1'b1);
        fld.pulses(0, 2);
        rd(gdc_pkg::ADDR_IRQ, 32'h100);
        rd(gdc_pkg::ADDR_STAT0, 32'h0101_0030);
        rd(gdc_pkg::ADDR_ACT0, 32'h0101_2710);
        fld.set_gate(0, 1'b0);
        rd(gdc_pkg::ADDR_FINAL0, 32'h0003_2710);
        rd(gdc_pkg::ADDR_IRQ, 32'h0);
        wr(gdc_pkg::ADDR_CTRL0, 32'h3);
        pins(3'b001);
        wr(gdc_pkg::ADDR_CTRL0, 32'h0);
        pins(3'b000);
        wr(gdc_pkg::ADDR_CTRL0, 32'h3);
        pins(3'b001);
        wr(gdc_pkg::ADDR_CFG0, 32'h8000_0011);
        pins(3'b000);
        fld.set_gate(1, 1'b1);
        wr(gdc_pkg::ADDR_INIT1, 32'h1);
        wr(gdc_pkg::ADDR_CFG1, 32'h8000_0f10);
        rd(gdc_pkg::ADDR_STAT1, 32'h0);
        rd(gdc_pkg::ADDR_ACT1, 32'h1);
        wr(gdc_pkg::ADDR_CTRL1, 32'h0000_8011);
        fld.pulses(1, 1);
        rd(gdc_pkg::ADDR_STAT1, 32'h0100_4030);
        pins(3'b010);
        rd(gdc_pkg::ADDR_IRQ, 32'h0);
        summarize();
    end
endmodule // gdc_counter_bench
bind gdc_counter gdc_assertions #(.CH(CH)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_gate_input(external_gate_input),
    .count_pulse(count_pulse), .digital_output_one(digital_output_one),
    .irq_request(irq_request));
`default_nettype wire

// [dv/gdc_field.sv]
`timescale 1ns/1ps
`default_nettype none
module gdc_field (
    input wire logic pclk,
    output logic [1:0] gate,
    output logic [1:0] pulse
);
    // ****************************************
    // Gate and pulse source
    // ****************************************
    initial begin
        gate = 2'b00;
        pulse = 2'b00;
    end
    task automatic set_gate(input int ch, input logic v);
        @(posedge pclk);
        gate[ch] <= v;
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            @(posedge pclk);
            pulse[ch] <= 1'b1;
            repeat (4) @(posedge pclk);
            pulse[ch] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask
endmodule // gdc_field
`default_nettype wire

// [logic/gdc_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module gdc_counter #(
    parameter int CH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CH-1:0] external_gate_input,
    input wire logic [CH-1:0] count_pulse,
    output logic [CH-1:0] digital_output_one,
    output logic irq_request
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic acc;
    logic wr;
    logic rd;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    logic irq_read;
    assign irq_read = rd & (paddr == gdc_pkg::ADDR_IRQ);
    logic [31:0] next_prdata;
    logic map_hit;
    logic [CH-1:0][31:0] stat_w;
    logic [CH-1:0][31:0] final_w;
    logic [CH-1:0][31:0] act_w;
    logic [CH-1:0][31:0] ctrl_w;
    logic [CH-1:0][31:0] cfg_w;
    logic [CH-1:0][15:0] init_w;
    logic [CH-1:0][15:0] irq_w;
    logic [CH-1:0] mode_ok;

    // ****************************************
    // Channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            localparam logic [11:0] OFS = 12'(g * 4);
            logic s1, s2, p1, p2, p3;
            logic [15:0] ctrl;
            logic [15:0] cfg;
            logic configured;
            logic signed [15:0] init_count;
            logic signed [15:0] count;
            logic signed [15:0] final_val;
            logic gate, gate_d;
            logic started, zero, ovr, fin, owr, fin_unread, out1, armed;
            logic zero_d, ovr_d, fin_d, owr_d;
            logic [3:0] irq;
            logic pulse, rise, fall, cfg_wr, stat_rd, mask;
            assign cfg_wr = wr & (paddr == gdc_pkg::ADDR_CFG0 + OFS);
            assign stat_rd = rd & (paddr == gdc_pkg::ADDR_STAT0 + OFS);
            assign mask = ctrl[gdc_pkg::CTRL_MASK];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    p1 <= 1'b0;
                    p2 <= 1'b0;
                    p3 <= 1'b0;
                end else begin
                    s1 <= external_gate_input[g];
                    s2 <= s1;
                    p1 <= count_pulse[g];
                    p2 <= p1;
                    p3 <= p2;
                end
            end
            assign pulse = p2 & ~p3;
            assign gate = configured & (cfg[gdc_pkg::CFG_GATE_SRC] ? s2
                : ctrl[gdc_pkg::CTRL_SOFT_GATE]);
            assign rise = gate & ~gate_d;
            assign fall = ~gate & gate_d;

            // Control and configuration
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl <= 16'h0000;
                    cfg <= 16'h0000;
                    configured <= 1'b0;
                    init_count <= 16'sh0000;
                end else begin
                    if (wr && paddr == gdc_pkg::ADDR_CTRL0 + OFS)
                        ctrl <= pwdata[15:0];
                    if (wr && paddr == gdc_pkg::ADDR_INIT0 + OFS)
                        init_count <= pwdata[15:0];
                    if (cfg_wr && pwdata[gdc_pkg::CFG_START]) begin
                        cfg <= pwdata[15:0];
                        configured <= ~pwdata[gdc_pkg::CFG_ERR];
                        ctrl <= 16'h0000;
                    end
                end
            end

            // Counting and flags
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_d <= 1'b0;
                    count <= 16'sh0000;
                    final_val <= 16'sh0000;
                    started <= 1'b0;
                    zero <= 1'b0;
                    ovr <= 1'b0;
                    fin <= 1'b0;
                    owr <= 1'b0;
                    fin_unread <= 1'b0;
                    armed <= 1'b0;
                end else begin
                    gate_d <= gate;
                    if (cfg_wr && pwdata[gdc_pkg::CFG_START]) begin
                        count <= init_count;
                        zero <= 1'b0;
                        ovr <= 1'b0;
                        fin <= 1'b0;
                        owr <= 1'b0;
                        started <= 1'b0;
                        fin_unread <= 1'b0;
                        armed <= 1'b0;
                    end else begin
                        if (rise) begin
                            count <= init_count;
                            zero <= 1'b0;
                        end else if (gate && pulse) begin
                            if (count > gdc_pkg::CNT_LIMIT - 16'sd1)
                                count <= count - 16'sd1;
                            if (count <= 16'sd1)
                                zero <= 1'b1;
                        end
                        // Only the first pulse after a gate rise
                        if (rise)
                            armed <= 1'b1;
                        else if (gate && pulse)
                            armed <= 1'b0;
                        if (gate && pulse && !rise && armed)
                            started <= 1'b1;
                        else if (stat_rd || rise)
                            started <= 1'b0;
                        // Set on entry so that a read can clear it
                        if (gate && pulse && !rise
                            && count == gdc_pkg::CNT_LIMIT)
                            ovr <= 1'b1;
                        else if (stat_rd || (irq_read && irq[2]))
                            ovr <= 1'b0;
                        if (fall) begin
                            final_val <= count;
                            fin <= 1'b1;
                            fin_unread <= 1'b1;
                        end else if (stat_rd)
                            fin <= 1'b0;
                        if (fall && fin_unread)
                            owr <= 1'b1;
                        else if (stat_rd)
                            owr <= 1'b0;
                        if (stat_rd && !fall)
                            fin_unread <= 1'b0;
                    end
                end
            end

            // Request latching; set beats read clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    zero_d <= 1'b0;
                    ovr_d <= 1'b0;
                    fin_d <= 1'b0;
                    owr_d <= 1'b0;
                    irq <= 4'h0;
                end else begin
                    zero_d <= zero;
                    ovr_d <= ovr;
                    fin_d <= fin;
                    owr_d <= owr;
                    if ((cfg_wr && pwdata[gdc_pkg::CFG_START]) || irq_read)
                        irq <= 4'h0;
                    if (!mask) begin
                        if (zero && !zero_d && cfg[gdc_pkg::CFG_SRC_LO
                            + gdc_pkg::SRC_ZERO])
                            irq[0] <= 1'b1;
                        if (fin && !fin_d && cfg[gdc_pkg::CFG_SRC_LO
                            + gdc_pkg::SRC_FINAL])
                            irq[1] <= 1'b1;
                        if (ovr && !ovr_d && cfg[gdc_pkg::CFG_SRC_LO
                            + gdc_pkg::SRC_OVR])
                            irq[2] <= 1'b1;
                        if (owr && !owr_d && cfg[gdc_pkg::CFG_SRC_LO
                            + gdc_pkg::SRC_OWR])
                            irq[3] <= 1'b1;
                    end
                end
            end

            // Output one
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    out1 <= 1'b0;
                else if (cfg_wr && pwdata[gdc_pkg::CFG_START])
                    out1 <= 1'b0;
                else if (!ctrl[gdc_pkg::CTRL_SELECT])
                    out1 <= 1'b0;
                else if (ctrl[gdc_pkg::CTRL_FORCE])
                    out1 <= 1'b1;
                else if (!cfg[gdc_pkg::CFG_ASSIGN])
                    out1 <= 1'b0;
                else if (rise)
                    out1 <= 1'b0;
                else if (zero && !zero_d && !ovr)
                    out1 <= 1'b1;
            end
            assign digital_output_one[g] = out1;

            logic [15:0] mag;
            logic [15:0] fmag;
            assign mag = count[15] ? 16'(-count) : count;
            assign fmag = final_val[15] ? 16'(-final_val) : final_val;
            always_comb begin
                stat_w[g] = 32'h00000000;
                stat_w[g][gdc_pkg::ST_STARTED] = started;
                stat_w[g][gdc_pkg::ST_ENABLED] = gate;
                stat_w[g][gdc_pkg::ST_OUT] = out1;
                stat_w[g][gdc_pkg::ST_SIGN] = count[15];
                stat_w[g][gdc_pkg::ST_OVR] = ovr;
                stat_w[g][gdc_pkg::ST_ZERO] = zero;
                stat_w[g][gdc_pkg::ST_FINAL] = fin;
                act_w[g] = {stat_w[g][31:16], 2'b00, mag[13:0]};
                final_w[g] = {18'h00000, fmag[13:0]};
                final_w[g][gdc_pkg::FN_SIGN] = final_val[15];
                final_w[g][gdc_pkg::FN_OVR] =
                    final_val < gdc_pkg::CNT_LIMIT;
                final_w[g][gdc_pkg::FN_OWR] = owr;
            end
            assign ctrl_w[g] = {16'h0000, ctrl};
            assign cfg_w[g] = {16'h0000, cfg};
            assign init_w[g] = init_count;
            assign irq_w[g] = {5'h00, irq[3], 1'b0, irq[2],
                6'h00, irq[1], irq[0]};
            assign mode_ok[g] = configured;
        end
    endgenerate

    // ****************************************
    // Read mux; host picks transfer by address
    // ****************************************
    always_comb begin
        next_prdata = 32'h00000000;
        map_hit = 1'b1;
        case (paddr)
            gdc_pkg::ADDR_CTRL0: next_prdata = ctrl_w[0];
            gdc_pkg::ADDR_CTRL1: next_prdata = ctrl_w[1];
            gdc_pkg::ADDR_CFG0: next_prdata = cfg_w[0];
            gdc_pkg::ADDR_CFG1: next_prdata = cfg_w[1];
            gdc_pkg::ADDR_INIT0: next_prdata = {16'h0000, init_w[0]};
            gdc_pkg::ADDR_INIT1: next_prdata = {16'h0000, init_w[1]};
            gdc_pkg::ADDR_STAT0: next_prdata = stat_w[0];
            gdc_pkg::ADDR_STAT1: next_prdata = stat_w[1];
            gdc_pkg::ADDR_FINAL0: next_prdata = final_w[0];
            gdc_pkg::ADDR_FINAL1: next_prdata = final_w[1];
            gdc_pkg::ADDR_ACT0: next_prdata = act_w[0];
            gdc_pkg::ADDR_ACT1: next_prdata = act_w[1];
            gdc_pkg::ADDR_IRQ: next_prdata = {irq_w[1], irq_w[0]};
            gdc_pkg::ADDR_MODE: next_prdata = {16'h0000,
                mode_ok[1] ? gdc_pkg::MODE_COUNTING : gdc_pkg::MODE_NONE,
                mode_ok[0] ? gdc_pkg::MODE_COUNTING
                : gdc_pkg::MODE_NONE};
            default: map_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Bus answer, no wait state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0;
            pslverr <= psel & ~penable & ~map_hit;
        end
    end

    // ****************************************
    // Interrupt request line
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_request <= 1'b0;
        else
            irq_request <= |{g_ch[0].irq, g_ch[1].irq};
    end
endmodule // gdc_counter
`default_nettype wire

// [shared/gdc_pkg.sv]
package gdc_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [11:0] ADDR_CTRL0 = 12'h000;
    localparam logic [11:0] ADDR_CTRL1 = 12'h004;
    localparam logic [11:0] ADDR_CFG0 = 12'h008;
    localparam logic [11:0] ADDR_CFG1 = 12'h00c;
    localparam logic [11:0] ADDR_INIT0 = 12'h010;
    localparam logic [11:0] ADDR_INIT1 = 12'h014;
    localparam logic [11:0] ADDR_STAT0 = 12'h018;
    localparam logic [11:0] ADDR_STAT1 = 12'h01c;
    localparam logic [11:0] ADDR_FINAL0 = 12'h020;
    localparam logic [11:0] ADDR_FINAL1 = 12'h024;
    localparam logic [11:0] ADDR_IRQ = 12'h028;
    localparam logic [11:0] ADDR_MODE = 12'h02c;
    localparam logic [11:0] ADDR_ACT0 = 12'h030;
    localparam logic [11:0] ADDR_ACT1 = 12'h034;
    // ****************************************
    // Control word fields
    // ****************************************
    localparam int CTRL_SELECT = 0;
    localparam int CTRL_FORCE = 1;
    localparam int CTRL_SOFT_GATE = 4;
    localparam int CTRL_MASK = 15;
    // ****************************************
    // Configuration word fields
    // ****************************************
    localparam int CFG_GATE_SRC = 0;
    localparam int CFG_ASSIGN = 4;
    localparam int CFG_SRC_LO = 8;
    localparam int CFG_ERR = 16;
    localparam int CFG_START = 31;
    // ****************************************
    // Status word fields
    // ****************************************
    localparam int ST_STARTED = 4;
    localparam int ST_ENABLED = 5;
    localparam int ST_OUT = 14;
    localparam int ST_SIGN = 16;
    localparam int ST_OVR = 17;
    localparam int ST_ZERO = 24;
    localparam int ST_FINAL = 25;
    // ****************************************
    // Final word fields
    // ****************************************
    localparam int FN_SIGN = 16;
    localparam int FN_OVR = 17;
    localparam int FN_OWR = 18;
    // ****************************************
    // Interrupt halfword fields, per channel
    // ****************************************
    localparam int IRQ_ZERO = 0;
    localparam int IRQ_FINAL = 1;
    localparam int IRQ_OVR = 8;
    localparam int IRQ_OWR = 10;
    localparam int IRQ_CH_STRIDE = 16;
    // ****************************************
    // Source select bits
    // ****************************************
    localparam int SRC_ZERO = 0;
    localparam int SRC_OVR = 1;
    localparam int SRC_FINAL = 2;
    localparam int SRC_OWR = 3;
    // ****************************************
    // Counter limits and mode
    // ****************************************
    localparam int CNT_W = 16;
    localparam logic signed [15:0] CNT_LIMIT = -16'sd9999;
    localparam logic [7:0] MODE_COUNTING = 8'h02;
    localparam logic [7:0] MODE_NONE = 8'h00;
endpackage
